// ### logic/msr_formatter.sv
// Serial report formatter: settings registers and message character sequencer.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Function
// - node address 0..199, reset value one
// - alarm status character sent when enabled
// - peak/valley status character sent when enabled
// - two bits choose filtered or unfiltered reading
// - peak and valley readings appended when enabled
// - separator is space or carriage return
// - unit of measure sent when enabled
// - checksum appended when enabled
// - line feed follows every carriage return
// - received characters echoed when enabled
// - bus mode point-to-point or multipoint
// - point-to-point continuous or on command
// - continuous handshake per message or character
// - flag records RS-485 board installed
// - external print input triggers when enabled
// - count readings in continuous mode, transmit at programmed count
// - four analog calibration constants up to 59999
// - characters always seven data bits
// - parity none/odd/even, one or two stops
// - no parity with one stop rejected
module msr_formatter (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Message sources
   input wire logic reading_done,
   input wire logic print_request,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_address,
   input wire logic [6:0] alarm_status_char,
   input wire logic [6:0] peak_valley_status_char,
   input wire logic [41:0] reading_filtered,
   input wire logic [41:0] reading_unfiltered,
   input wire logic [41:0] reading_peak,
   input wire logic [41:0] reading_valley,
   input wire logic [13:0] unit_chars,
   // Character stream towards the UART engine
   output logic [6:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire logic host_clear,
   // Echo path
   input wire logic [6:0] rx_data,
   input wire logic rx_valid,
   output logic [6:0] echo_data,
   output logic echo_valid,
   // Line settings for the UART engine and board
   output logic [1:0] parity_select,
   output logic stop_bits_select,
   output logic rs485_installed
);

   // ----------------
   // Helpers
   // ----------------
   function automatic logic [6:0] pick_char(input logic [41:0] field, input logic [2:0] idx);
      logic [5:0] pos;
      pos = 6'(3'h5 - idx) * 6'h07;
      pick_char = field[pos +: 7];
   endfunction : pick_char

   function automatic logic [6:0] hex_char(input logic [3:0] nib);
      hex_char = (nib < 4'hA) ? (msr_pkg::CH_ZERO + 7'(nib)) : (msr_pkg::CH_A_LESS_10 + 7'(nib));
   endfunction : hex_char

   // ----------------
   // Settings registers
   // ----------------
   logic [7:0] node_address;
   logic [7:0] message_content;
   logic [7:0] line_format;
   logic [15:0] readings_per_transmission;
   logic [15:0] cal [4];
   logic cfg_rejected;

   wire in_cal = (reg_addr >= msr_pkg::OFS_CAL_BASE) && (reg_addr < msr_pkg::OFS_STATUS);
   wire [1:0] cal_sel = 2'(reg_addr - msr_pkg::OFS_CAL_BASE);
   wire [1:0] wr_parity = reg_wdata[1:0];
   wire wr_stop = reg_wdata[2];
   wire addr_ok = reg_wdata <= 16'(msr_pkg::MAX_NODE_ADDRESS);
   wire serial_ok = (wr_parity <= msr_pkg::MAX_PARITY) &&
                    !(wr_parity == msr_pkg::PARITY_NONE && !wr_stop);
   wire count_ok = (reg_wdata != 16'h0000) && (reg_wdata <= msr_pkg::MAX_COUNT);
   wire cal_ok = reg_wdata <= msr_pkg::MAX_COUNT;
   wire wr_node = reg_wr && reg_addr == msr_pkg::OFS_NODE_ADDRESS;
   wire wr_serial = reg_wr && reg_addr == msr_pkg::OFS_SERIAL_CONFIG;
   wire wr_count = reg_wr && reg_addr == msr_pkg::OFS_READINGS_PER_TX;
   wire wr_cal = reg_wr && in_cal;
   wire reject = (wr_node && !addr_ok) || (wr_serial && !serial_ok) ||
                 (wr_count && !count_ok) || (wr_cal && !cal_ok);
   wire rd_status = reg_rd && reg_addr == msr_pkg::OFS_STATUS;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         node_address <= msr_pkg::RST_NODE_ADDRESS;
         message_content <= msr_pkg::RST_MESSAGE_CONTENT;
         line_format <= msr_pkg::RST_LINE_FORMAT;
         parity_select <= msr_pkg::RST_PARITY;
         stop_bits_select <= msr_pkg::RST_STOP_BITS;
         readings_per_transmission <= msr_pkg::RST_READINGS_PER_TX;
         rs485_installed <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            cal[i] <= msr_pkg::RST_CAL;
         end
      end else begin
         if (wr_node && addr_ok) begin
            node_address <= reg_wdata[7:0];
         end
         if (reg_wr && reg_addr == msr_pkg::OFS_MESSAGE_CONTENT) begin
            message_content <= reg_wdata[7:0];
         end
         if (reg_wr && reg_addr == msr_pkg::OFS_LINE_FORMAT) begin
            line_format <= reg_wdata[7:0];
            rs485_installed <= reg_wdata[msr_pkg::LF_RS485];
         end
         if (wr_serial && serial_ok) begin
            parity_select <= wr_parity;
            stop_bits_select <= wr_stop;
         end
         if (wr_count && count_ok) begin
            readings_per_transmission <= reg_wdata;
         end
         if (wr_cal && cal_ok) begin
            cal[cal_sel] <= reg_wdata;
         end
      end
   end

   // A rejected write leaves the old value and raises a sticky flag; a read of
   // the status register clears it unless a new rejection lands in that cycle.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_rejected <= 1'b0;
      end else begin
         cfg_rejected <= reject || (cfg_rejected && !rd_status);
      end
   end

   // ----------------
   // Decoded settings
   // ----------------
   wire multipoint = line_format[msr_pkg::LF_MULTIPOINT];
   wire continuous = !multipoint && !line_format[msr_pkg::LF_ON_COMMAND];
   wire per_char = line_format[msr_pkg::LF_PER_CHAR];
   wire lf_enable = line_format[msr_pkg::LF_LINE_FEED];
   wire use_filtered = message_content[msr_pkg::MC_FILTERED_A] ||
                       message_content[msr_pkg::MC_FILTERED_B];
   wire [6:0] sep_char = message_content[msr_pkg::MC_SEPARATOR] ?
                         msr_pkg::CH_CR : msr_pkg::CH_SPACE;
   wire flow_ok = !continuous || host_clear;
   wire msg_gate = per_char || flow_ok;
   wire char_gate = !per_char || flow_ok;

   // ----------------
   // Triggers and reading counter
   // ----------------
   logic [15:0] reading_count;
   logic pending;
   msr_pkg::msr_state_t state;

   wire count_hit = continuous && reading_done &&
                    (reading_count + 16'h0001 >= readings_per_transmission);
   wire cmd_hit = cmd_valid && !continuous &&
                  (!multipoint || cmd_address == node_address);
   wire print_hit = print_request && line_format[msr_pkg::LF_EXT_PRINT];
   wire start_msg = state == msr_pkg::ST_IDLE && pending && msg_gate;
   wire [15:0] next_reading_count = !continuous ? 16'h0000 :
                                    count_hit ? 16'h0000 :
                                    reading_done ? reading_count + 16'h0001 : reading_count;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reading_count <= 16'h0000;
         pending <= 1'b0;
      end else begin
         reading_count <= next_reading_count;
         // A new trigger in the cycle that takes the old one is kept.
         pending <= count_hit || cmd_hit || print_hit || (pending && !start_msg);
      end
   end

   // ----------------
   // Message sequencer
   // ----------------
   logic [2:0] item;
   logic [2:0] idx;
   logic started;
   logic sep_done;
   logic lf_due;
   logic [7:0] checksum;
   logic end_pending;
   logic item_en [8];
   assign item_en[0] = message_content[msr_pkg::MC_ALARM_STATUS];
   assign item_en[1] = message_content[msr_pkg::MC_PV_STATUS];
   assign item_en[2] = 1'b1;
   assign item_en[3] = message_content[msr_pkg::MC_PEAK];
   assign item_en[4] = message_content[msr_pkg::MC_VALLEY];
   assign item_en[5] = message_content[msr_pkg::MC_UNIT];
   assign item_en[6] = line_format[msr_pkg::LF_CHECKSUM];
   assign item_en[7] = 1'b1;

   wire [2:0] item_len = (item == msr_pkg::IT_READING || item == msr_pkg::IT_PEAK ||
                          item == msr_pkg::IT_VALLEY) ? msr_pkg::LEN_VALUE :
                         (item == msr_pkg::IT_UNIT || item == msr_pkg::IT_CHECKSUM) ?
                         msr_pkg::LEN_PAIR : msr_pkg::LEN_ONE;
   wire [41:0] unit_field = {unit_chars, 28'h0000000};
   wire [41:0] sum_field = {hex_char(checksum[7:4]), hex_char(checksum[3:0]), 28'h0000000};
   wire [6:0] field_char =
      (item == msr_pkg::IT_ALARM) ? alarm_status_char :
      (item == msr_pkg::IT_PV) ? peak_valley_status_char :
      (item == msr_pkg::IT_READING) ?
         pick_char(use_filtered ? reading_filtered : reading_unfiltered, idx) :
      (item == msr_pkg::IT_PEAK) ? pick_char(reading_peak, idx) :
      (item == msr_pkg::IT_VALLEY) ? pick_char(reading_valley, idx) :
      (item == msr_pkg::IT_UNIT) ? pick_char(unit_field, idx) :
      (item == msr_pkg::IT_CHECKSUM) ? pick_char(sum_field, idx) : msr_pkg::CH_CR;

   // Items after the first enabled one are preceded by one separator; the
   // closing carriage return has none.
   wire want_sep = item_en[item] && idx == 3'h0 && started && !sep_done &&
                   item != msr_pkg::IT_END;
   wire [6:0] next_char = lf_due ? msr_pkg::CH_LF : want_sep ? sep_char : field_char;
   wire emit = state == msr_pkg::ST_SELECT && char_gate && (lf_due || item_en[item]);
   wire item_last = idx == item_len - 3'h1;
   wire field_step = emit && !lf_due && !want_sep;
   wire msg_done = emit && ((lf_due && item == msr_pkg::IT_END) ||
                            (field_step && item == msr_pkg::IT_END && !lf_enable));
   wire chk_field = field_step && item == msr_pkg::IT_CHECKSUM;
   wire sum_char = emit && item <= msr_pkg::IT_CHECKSUM && !chk_field;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= msr_pkg::ST_IDLE;
         item <= msr_pkg::IT_ALARM;
         idx <= 3'h0;
         started <= 1'b0;
         sep_done <= 1'b0;
         lf_due <= 1'b0;
         checksum <= 8'h00;
         end_pending <= 1'b0;
      end else begin
         case (state)
            msr_pkg::ST_IDLE: begin
               if (start_msg) begin
                  state <= msr_pkg::ST_SELECT;
                  item <= msr_pkg::IT_ALARM;
                  idx <= 3'h0;
                  started <= 1'b0;
                  sep_done <= 1'b0;
                  lf_due <= 1'b0;
                  checksum <= 8'h00;
               end
            end
            msr_pkg::ST_SELECT: begin
               if (emit) begin
                  state <= msr_pkg::ST_SEND;
                  if (lf_due) begin
                     lf_due <= 1'b0;
                  end else if (want_sep) begin
                     sep_done <= 1'b1;
                     lf_due <= lf_enable && sep_char == msr_pkg::CH_CR;
                  end else begin
                     if (item_last) begin
                        idx <= 3'h0;
                        started <= 1'b1;
                        sep_done <= 1'b0;
                        lf_due <= item == msr_pkg::IT_END && lf_enable;
                        if (item != msr_pkg::IT_END) begin
                           item <= item + 3'h1;
                        end
                     end else begin
                        idx <= idx + 3'h1;
                     end
                  end
                  if (sum_char) begin
                     checksum <= checksum + {1'b0, next_char};
                  end
                  end_pending <= msg_done;
               end else if (!item_en[item]) begin
                  item <= item + 3'h1;
               end
            end
            msr_pkg::ST_SEND: begin
               if (tx_ready) begin
                  state <= end_pending ? msr_pkg::ST_IDLE : msr_pkg::ST_SELECT;
               end
            end
            default: begin
               state <= msr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------
   // Registered outputs
   // ----------------
   wire [15:0] status_word = {13'h0000, pending, cfg_rejected,
                              state != msr_pkg::ST_IDLE};
   wire [2:0] serial_word = {stop_bits_select, parity_select};
   wire [15:0] read_mux =
      (reg_addr == msr_pkg::OFS_NODE_ADDRESS) ? {8'h00, node_address} :
      (reg_addr == msr_pkg::OFS_MESSAGE_CONTENT) ? {8'h00, message_content} :
      (reg_addr == msr_pkg::OFS_LINE_FORMAT) ? {8'h00, line_format} :
      (reg_addr == msr_pkg::OFS_SERIAL_CONFIG) ? {13'h0000, serial_word} :
      (reg_addr == msr_pkg::OFS_READINGS_PER_TX) ? readings_per_transmission :
      in_cal ? cal[cal_sel] :
      (reg_addr == msr_pkg::OFS_STATUS) ? status_word : 16'h0000;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
         tx_data <= 7'h00;
         tx_valid <= 1'b0;
         echo_data <= 7'h00;
         echo_valid <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? read_mux : 16'h0000;
         if (emit) begin
            tx_data <= next_char;
         end
         tx_valid <= emit || (tx_valid && !tx_ready);
         echo_data <= rx_data;
         echo_valid <= rx_valid && line_format[msr_pkg::LF_ECHO];
      end
   end

endmodule : msr_formatter

// ### logic/msr_pkg.sv
// Constants, register map and state codes of the serial report formatter.
package msr_pkg;

   // ----------------
   // Register map (word index on the plain register port)
   // ----------------
   localparam logic [3:0] OFS_NODE_ADDRESS = 4'h0;
   localparam logic [3:0] OFS_MESSAGE_CONTENT = 4'h1;
   localparam logic [3:0] OFS_LINE_FORMAT = 4'h2;
   localparam logic [3:0] OFS_SERIAL_CONFIG = 4'h3;
   localparam logic [3:0] OFS_READINGS_PER_TX = 4'h4;
   localparam logic [3:0] OFS_CAL_BASE = 4'h5;
   localparam logic [3:0] OFS_STATUS = 4'h9;

   // ----------------
   // Values after reset and limits
   // ----------------
   localparam logic [7:0] RST_NODE_ADDRESS = 8'h01;
   localparam logic [7:0] RST_MESSAGE_CONTENT = 8'h04;
   localparam logic [7:0] RST_LINE_FORMAT = 8'h94;
   localparam logic [1:0] RST_PARITY = 2'h0;
   localparam logic RST_STOP_BITS = 1'b1;
   localparam logic [15:0] RST_READINGS_PER_TX = 16'h0001;
   localparam logic [15:0] RST_CAL = 16'h0000;
   localparam logic [7:0] MAX_NODE_ADDRESS = 8'hC7;
   localparam logic [15:0] MAX_COUNT = 16'hEA5F;
   localparam logic [1:0] MAX_PARITY = 2'h2;
   localparam logic [1:0] PARITY_NONE = 2'h0;

   // ----------------
   // Field positions in the message-content register
   // ----------------
   localparam int MC_ALARM_STATUS = 0;
   localparam int MC_PV_STATUS = 1;
   localparam int MC_FILTERED_A = 2;
   localparam int MC_FILTERED_B = 3;
   localparam int MC_PEAK = 4;
   localparam int MC_VALLEY = 5;
   localparam int MC_SEPARATOR = 6;
   localparam int MC_UNIT = 7;

   // ----------------
   // Field positions in the line-format register
   // ----------------
   localparam int LF_CHECKSUM = 0;
   localparam int LF_LINE_FEED = 1;
   localparam int LF_ECHO = 2;
   localparam int LF_MULTIPOINT = 3;
   localparam int LF_ON_COMMAND = 4;
   localparam int LF_PER_CHAR = 5;
   localparam int LF_RS485 = 6;
   localparam int LF_EXT_PRINT = 7;

   // ----------------
   // Status register bits
   // ----------------
   localparam int ST_BUSY = 0;
   localparam int ST_REJECTED = 1;
   localparam int ST_PENDING = 2;

   // ----------------
   // Characters and message items
   // ----------------
   localparam logic [6:0] CH_SPACE = 7'h20;
   localparam logic [6:0] CH_CR = 7'h0D;
   localparam logic [6:0] CH_LF = 7'h0A;
   localparam logic [6:0] CH_ZERO = 7'h30;
   localparam logic [6:0] CH_A_LESS_10 = 7'h37;
   localparam logic [2:0] IT_ALARM = 3'h0;
   localparam logic [2:0] IT_PV = 3'h1;
   localparam logic [2:0] IT_READING = 3'h2;
   localparam logic [2:0] IT_PEAK = 3'h3;
   localparam logic [2:0] IT_VALLEY = 3'h4;
   localparam logic [2:0] IT_UNIT = 3'h5;
   localparam logic [2:0] IT_CHECKSUM = 3'h6;
   localparam logic [2:0] IT_END = 3'h7;
   localparam logic [2:0] LEN_VALUE = 3'h6;
   localparam logic [2:0] LEN_PAIR = 3'h2;
   localparam logic [2:0] LEN_ONE = 3'h1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SELECT = 3'b010,
      ST_SEND = 3'b100
   } msr_state_t;

endpackage : msr_pkg

// ### sim/msr_formatter_chk.sv
// Port assertions for the serial report formatter.
`timescale 1ns/100ps
module msr_formatter_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Character stream and echo
   input wire logic [6:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [6:0] rx_data,
   input wire logic rx_valid,
   input wire logic [6:0] echo_data,
   input wire logic echo_valid,
   // Line settings
   input wire logic [1:0] parity_select,
   input wire logic stop_bits_select,
   input wire logic rs485_installed
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ----------------
   // Properties
   // ----------------
   property p_rdata_quiet; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
   a_rdata_quiet: assert property (p_rdata_quiet)
      else $error("read data outside its slot");
   property p_echo; echo_valid |-> $past(rx_valid) && echo_data == $past(rx_data); endproperty
   a_echo: assert property (p_echo)
      else $error("echo without matching received character");
   property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("character dropped or changed before acceptance");
   property p_tx_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
   a_tx_gap: assert property (p_tx_gap)
      else $error("character offered right after acceptance");
   property p_parity_legal; parity_select != 2'h3; endproperty
   a_parity_legal: assert property (p_parity_legal)
      else $error("parity code out of range");
   property p_no_bad_combo; !(parity_select == 2'h0 && !stop_bits_select); endproperty
   a_no_bad_combo: assert property (p_no_bad_combo)
      else $error("no parity with one stop bit in use");
   property p_line_hold;
      !$past(reg_wr) |-> $stable({parity_select, stop_bits_select, rs485_installed});
   endproperty
   a_line_hold: assert property (p_line_hold)
      else $error("line setting changed without a write");
   property p_serial_write;
      reg_wr && reg_addr == msr_pkg::OFS_SERIAL_CONFIG && reg_wdata[1:0] != 2'h3
         && (reg_wdata[1:0] != 2'h0 || reg_wdata[2])
      |=> parity_select == $past(reg_wdata[1:0]) && stop_bits_select == $past(reg_wdata[2]);
   endproperty
   a_serial_write: assert property (p_serial_write)
      else $error("valid serial setting not taken");
   property p_rs485_write;
      reg_wr && reg_addr == msr_pkg::OFS_LINE_FORMAT |=> rs485_installed == $past(reg_wdata[6]);
   endproperty
   a_rs485_write: assert property (p_rs485_write)
      else $error("board flag does not follow write");
   c_accept: cover property (tx_valid && tx_ready);
   c_echo: cover property (echo_valid);
   c_serial: cover property (reg_wr && reg_addr == msr_pkg::OFS_SERIAL_CONFIG);
endmodule : msr_formatter_chk

bind msr_formatter msr_formatter_chk chk (.*);

// ### sim/msr_host_model.sv
// Behavioural host end of the character stream that records every character taken.
`timescale 1ns/100ps
module msr_host_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Character stream
   input wire logic [6:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic host_clear,
   // Test controls
   input wire logic slow,
   input wire logic pause
);
   logic [6:0] rxq[$];
   logic [1:0] lag;
   // A slow host is ready one cycle in four, so each character must be held.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lag <= 2'h0;
         tx_ready <= 1'b0;
      end else begin
         lag <= lag + 2'h1;
         tx_ready <= !slow || lag == 2'h3;
         if (tx_valid && tx_ready) rxq.push_back(tx_data);
      end
   end
   assign host_clear = !pause;
endmodule : msr_host_model

// ### sim/tb.sv
// Self-checking testbench of the serial report formatter.
`timescale 1ns/100ps
module tb;
   typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} msr_row_t;
   logic mclk, reset_n, reg_wr, reg_rd, reading_done, print_request, cmd_valid, rx_valid;
   logic tx_valid, tx_ready, host_clear, echo_valid, stop_bits_select, rs485_installed;
   logic slow, pause;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, q;
   logic [7:0] cmd_address;
   logic [6:0] alarm_status_char, peak_valley_status_char, tx_data, rx_data, echo_data;
   logic [41:0] reading_filtered, reading_unfiltered, reading_peak, reading_valley;
   logic [13:0] unit_chars;
   logic [1:0] parity_select;
   logic [6:0] exp[$];
   int miscompares = 0;
   int checks = 0;
   logic [15:0] rst_vals[9] = '{16'h0001, 16'h0004, 16'h0094, 16'h0004, 16'h0001,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
   msr_row_t rows[16] = '{'{4'h0, 16'h00C7, 16'h00C7}, '{4'h0, 16'h00C8, 16'h00C7},
      '{4'h0, 16'h0000, 16'h0000}, '{4'h1, 16'hFFFF, 16'h00FF},
      '{4'h4, 16'hEA5F, 16'hEA5F}, '{4'h4, 16'h0000, 16'hEA5F},
      '{4'h4, 16'hEA60, 16'hEA5F}, '{4'h5, 16'hEA5F, 16'hEA5F},
      '{4'h6, 16'hEA60, 16'h0000}, '{4'h7, 16'h1234, 16'h1234},
      '{4'h8, 16'hEA5F, 16'hEA5F}, '{4'h3, 16'h0001, 16'h0001},
      '{4'h3, 16'h0003, 16'h0001}, '{4'h3, 16'h0000, 16'h0001},
      '{4'h3, 16'h0006, 16'h0006}, '{4'hA, 16'hFFFF, 16'h0000}};

   msr_formatter dut (.*);
   msr_host_model host (.*);

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ----------------
   // Bus cycles, comparisons and expected messages
   // ----------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] want);
      checks++;
      if (got !== want) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, want);
      end
   endtask : cmp
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // Argument bits select reading_done, print_request and cmd_valid, high first.
   task automatic pulse(input logic [2:0] which);
      @(posedge mclk) {reading_done, print_request, cmd_valid} <= which;
      @(posedge mclk) {reading_done, print_request, cmd_valid} <= 3'h0;
   endtask : pulse
   task automatic put(input logic [6:0] c);
      exp.push_back(c);
   endtask : put
   task automatic sep(input logic [7:0] mc, input logic [7:0] lf);
      if (exp.size() != 0) begin
         put(mc[6] ? msr_pkg::CH_CR : msr_pkg::CH_SPACE);
         if (mc[6] && lf[1]) put(msr_pkg::CH_LF);
      end
   endtask : sep
   task automatic val(input logic [41:0] v, input logic [7:0] mc, input logic [7:0] lf);
      sep(mc, lf);
      for (int i = 0; i < 6; i++) put(v[41 - 7 * i -: 7]);
   endtask : val
   function automatic logic [6:0] hex(input logic [3:0] n);
      return (n < 4'hA ? msr_pkg::CH_ZERO : msr_pkg::CH_A_LESS_10) + {3'h0, n};
   endfunction : hex
   task automatic build(input logic [7:0] mc, input logic [7:0] lf);
      logic [7:0] s;
      exp = {};
      s = 8'h00;
      if (mc[0]) put(alarm_status_char);
      if (mc[1]) begin
         sep(mc, lf);
         put(peak_valley_status_char);
      end
      val(mc[2] | mc[3] ? reading_filtered : reading_unfiltered, mc, lf);
      if (mc[4]) val(reading_peak, mc, lf);
      if (mc[5]) val(reading_valley, mc, lf);
      if (mc[7]) begin
         sep(mc, lf);
         put(unit_chars[13:7]);
         put(unit_chars[6:0]);
      end
      if (lf[0]) begin
         sep(mc, lf);
         foreach (exp[i]) s = s + {1'b0, exp[i]};
         put(hex(s[7:4]));
         put(hex(s[3:0]));
      end
      put(msr_pkg::CH_CR);
      if (lf[1]) put(msr_pkg::CH_LF);
   endtask : build
   task automatic msg();
      for (int i = 0; i < 3000 && host.rxq.size() < exp.size(); i++) @(posedge mclk);
      repeat (30) @(posedge mclk);
      cmp(16'(host.rxq.size()), 16'(exp.size()));
      foreach (exp[k]) cmp({9'h0, host.rxq[k]}, {9'h0, exp[k]});
      host.rxq = {};
   endtask : msg
   task automatic quiet(input int n);
      repeat (n) @(posedge mclk);
      cmp(16'(host.rxq.size()), 16'h0000);
   endtask : quiet
   task automatic echo(input logic on);
      @(posedge mclk) rx_data <= 7'h55;
      rx_valid <= 1'b1;
      @(posedge mclk) rx_valid <= 1'b0;
      #1 cmp({8'h00, echo_valid, on ? echo_data : 7'h55}, {8'h00, on, 7'h55});
   endtask : echo
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done

   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      test_done();
   end

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      reset_n = 1'b0;
      {reg_wr, reg_rd, reading_done, print_request, cmd_valid, rx_valid, slow, pause} = 8'h00;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      cmd_address = 8'h00;
      rx_data = 7'h00;
      alarm_status_char = 7'h41;
      peak_valley_status_char = 7'h48;
      reading_filtered = {7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35};
      reading_unfiltered = {6{7'h35}};
      reading_peak = {6{7'h39}};
      reading_valley = {6{7'h31}};
      unit_chars = {7'h6D, 7'h56};
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      for (int a = 0; a < 9; a++) begin
         rd(4'(a), q);
         cmp(q, rst_vals[a]);
      end
      cmp({12'h000, rs485_installed, stop_bits_select, parity_select}, 16'h0004);
      slow <= 1'b1;
      build(8'h04, 8'h94);
      pulse(3'h2);
      msg();
      slow <= 1'b0;
      echo(1'b1);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, q);
         cmp(q, rows[i].e);
      end
      cmp({14'h0000, parity_select}, 16'h0002);
      wr(4'h0, 16'h00C8);
      rd(4'h9, q);
      cmp(q & 16'h0002, 16'h0002);
      rd(4'h9, q);
      cmp(q & 16'h0002, 16'h0000);
      wr(4'h1, 16'h00FF);
      wr(4'h2, 16'h0097);
      build(8'hFF, 8'h97);
      pulse(3'h1);
      msg();
      wr(4'h0, 16'h002A);
      wr(4'h1, 16'h0000);
      wr(4'h2, 16'h0048);
      #1 cmp({15'h0000, rs485_installed}, 16'h0001);
      echo(1'b0);
      build(8'h00, 8'h48);
      cmd_address <= 8'h2B;
      pulse(3'h1);
      quiet(40);
      cmd_address <= 8'h2A;
      pulse(3'h1);
      msg();
      wr(4'h4, 16'h0003);
      wr(4'h2, 16'h0000);
      build(8'h00, 8'h00);
      pulse(3'h4);
      pulse(3'h4);
      pulse(3'h2);
      quiet(40);
      pause <= 1'b1;
      pulse(3'h4);
      quiet(40);
      pause <= 1'b0;
      msg();
      wr(4'h4, 16'h0001);
      wr(4'h2, 16'h0020);
      pause <= 1'b1;
      pulse(3'h4);
      quiet(40);
      rd(4'h9, q);
      cmp(q & 16'h0001, 16'h0001);
      @(posedge mclk) pause <= 1'b0;
      msg();
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(4'h0, q);
      cmp(q, 16'h0001);
      test_done();
   end
endmodule : tb
